// File: dv/serial_dac_input_latch_test.sv
// Self-checking bench for the serial DAC load interface
`timescale 1ns/1ps
module serial_dac_input_latch_test;
    logic        core_clk      = 1'b0;
    logic        sys_rst       = 1'b1;
    logic        async_clear_n = 1'b1;
    logic        load_sel_n;
    logic        ser_clk;
    logic        ser_data;
    logic [15:0] dac_code;
    logic [15:0] bip_code;
    logic        dac_update;
    logic        frame_active;
    logic        frame_short;
    logic        powerup_done;
    int          mismatches    = 0;
    int          n_checks      = 0;
    int          cycles        = 0;

    always #2.5 core_clk = ~core_clk;

    serial_host_model host_u (.core_clk(core_clk), .powerup_done(powerup_done),
        .load_sel_n(load_sel_n), .ser_clk(ser_clk), .ser_data(ser_data));

    serial_dac_input_latch #(.POWERUP_CYCLES(20)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .load_sel_n(load_sel_n), .ser_clk(ser_clk), .ser_data(ser_data), .async_clear_n(async_clear_n),
        .dac_code(dac_code), .dac_update(dac_update), .frame_active(frame_active),
        .frame_short(frame_short), .powerup_done(powerup_done));

    serial_dac_input_latch #(.VARIANT(dac_load_pkg::VARIANT_BIPOLAR), .POWERUP_CYCLES(20)) dut_bip_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .load_sel_n(load_sel_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .async_clear_n(async_clear_n), .dac_code(bip_code), .dac_update(),
        .frame_active(), .frame_short(), .powerup_done());

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wait_update;
        int k;
        k = 0;
        @(negedge load_sel_n);
        repeat (6) @(negedge core_clk);
        check({15'h0, frame_active}, 16'h0001);
        @(posedge load_sel_n);
        while (dac_update !== 1'b1 && k < 40) begin
            @(negedge core_clk);
            k++;
        end
        check({15'h0, dac_update}, 16'h0001);
    endtask

    task automatic frame(input logic [31:0] w, input int n, input logic [15:0] exp, input logic sh);
        fork
            host_u.send(w, n);
            wait_update;
        join
        check({15'h0, frame_short}, {15'h0, sh});
        if (!sh) begin
            check(dac_code, exp);
            check(bip_code, exp);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        check(dac_code, 16'h0000);
        check(bip_code, 16'h8000);
        repeat (19) @(negedge core_clk);
        check({15'h0, powerup_done}, 16'h0000);
        @(negedge core_clk);
        check({15'h0, powerup_done}, 16'h0001);
    endtask

    task automatic test_msb_first;
        frame(32'h0000_A5C3, 16, 16'hA5C3, 1'b0);
    endtask

    task automatic test_long;
        frame(32'h0001_BEEF, 20, 16'hBEEF, 1'b0);
    endtask

    task automatic test_short;
        frame(32'h0000_005A, 8, 16'h0000, 1'b1);
    endtask

    task automatic test_narrow;
        frame(32'h0000_ABC5, 16, 16'hABC5, 1'b0);
    endtask

    task automatic test_stray;
        host_u.stray(4);
        check(dac_code, 16'hABC5);
        check({15'h0, frame_active}, 16'h0000);
        check(bip_code, 16'hABC5);
    endtask

    task automatic test_clear;
        async_clear_n = 1'b0;
        repeat (6) @(negedge core_clk);
        check(dac_code, 16'h0000);
        check(bip_code, 16'h8000);
        async_clear_n = 1'b1;
        repeat (30) @(negedge core_clk);
        check(dac_code, 16'h0000);
        check(bip_code, 16'h8000);
    endtask

    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        test_reset;
        test_msb_first;
        test_long;
        test_short;
        test_narrow;
        test_stray;
        test_clear;
        finish_test;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test;
        end
    end
endmodule

// File: dv/serial_host_model.sv
// Host-side serial master model for the DAC load interface
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic core_clk,
    input  wire logic powerup_done,
    output logic      load_sel_n,
    output logic      ser_clk,
    output logic      ser_data
);
    initial begin
        load_sel_n = 1'b1;
        ser_clk    = 1'b0;
        ser_data   = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One frame, 16 core cycles per serial phase, clock idles low
    task automatic send(input logic [31:0] word, input int nbits);
        wait (powerup_done === 1'b1);
        gap(1);
        load_sel_n = 1'b0;
        gap(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data = word[i];
            gap(16);
            ser_clk = 1'b1;
            gap(16);
            ser_clk = 1'b0;
        end
        gap(4);
        load_sel_n = 1'b1;
        ser_data   = ~ser_data;
        gap(8);
    endtask

    // Serial clock edges while the select is released
    task automatic stray(input int n);
        repeat (n) begin
            ser_data = ~ser_data;
            ser_clk  = ~ser_clk;
            gap(8);
        end
    endtask
endmodule

// File: rtl/dac_load_defines.svh
// Constants for the serial DAC load interface
`ifndef DAC_LOAD_DEFINES_SVH
`define DAC_LOAD_DEFINES_SVH

`define DAC_WORD_BITS       16
`define DAC_ZERO_CODE       16'h0000
`define DAC_MID_CODE        16'h8000
`define DAC_CORE_CLK_MHZ    200
`define DAC_POWERUP_US      30
`define DAC_POWERUP_CYCLES  (`DAC_POWERUP_US * `DAC_CORE_CLK_MHZ)

`endif

// File: rtl/dac_load_pkg.sv
// Types for the serial DAC load interface
package dac_load_pkg;

    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'b00,
        FRAME_SHIFT = 2'b01
    } frame_state_e;

    typedef enum logic {
        VARIANT_UNIPOLAR = 1'b0,
        VARIANT_BIPOLAR  = 1'b1
    } variant_e;

endpackage

// File: rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int          WIDTH    = 1,
    parameter logic [31:0] INIT_VAL = 32'h0000_0000
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] stage_one;

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("pin_sync width out of range");
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage_one <= INIT_VAL[WIDTH-1:0];
            pin_out   <= INIT_VAL[WIDTH-1:0];
        end else begin
            stage_one <= pin_in;
            pin_out   <= stage_one;
        end
    end

endmodule

// File: rtl/serial_dac_input_latch.sv
// Serial load interface and DAC latch of a voltage-output DAC
// Functional notes
// - While load select is low, rising serial clock edges shift data into shift register.
// - Select rising edge ignores clocks, copies 16-bit shift register into latch.
// - Data bit is captured on the serial clock rising edge.
// - Unipolar variant: clear low forces latch to code zero.
// - Bipolar variant: clear low forces latch to midscale code.
// - Frames are MSB first; first bit shifted ends as latch top bit.
// - More than 16 edges per frame: only last 16 bits reach latch.
`timescale 1ns/1ps
`include "dac_load_defines.svh"
module serial_dac_input_latch #(
    parameter int                 WORD_BITS      = `DAC_WORD_BITS,
    parameter dac_load_pkg::variant_e VARIANT    = dac_load_pkg::VARIANT_UNIPOLAR,
    parameter int                 POWERUP_CYCLES = `DAC_POWERUP_CYCLES
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 load_sel_n,
    input  wire logic                 ser_clk,
    input  wire logic                 ser_data,
    input  wire logic                 async_clear_n,
    output logic      [WORD_BITS-1:0] dac_code,
    output logic                      dac_update,
    output logic                      frame_active,
    output logic                      frame_short,
    output logic                      powerup_done
);

    // ------------------------------------------------------------
    // Elaboration checks and constants
    // ------------------------------------------------------------
    if (WORD_BITS != `DAC_WORD_BITS) begin : g_bad_width
        $error("serial_dac_input_latch supports only a 16-bit word");
    end
    if (POWERUP_CYCLES < 1) begin : g_bad_powerup
        $error("POWERUP_CYCLES must be at least one");
    end

    localparam logic [15:0] CLEAR_CODE = (VARIANT == dac_load_pkg::VARIANT_BIPOLAR) ?
                                         `DAC_MID_CODE : `DAC_ZERO_CODE;
    localparam logic [31:0] PU_LAST    = 32'(POWERUP_CYCLES - 1);

    function automatic logic rise(input logic prev, input logic now);
        return !prev && now;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_sync;
    logic       sel_n_s;
    logic       sclk_s;
    logic       sdata_s;
    logic       clr_n_s;

    pin_sync #(
        .WIDTH    (4),
        .INIT_VAL (32'h0000_0009)
    ) u_pin_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   ({async_clear_n, ser_data, ser_clk, load_sel_n}),
        .pin_out  (pins_sync)
    );

    assign sel_n_s = pins_sync[0];
    assign sclk_s  = pins_sync[1];
    assign sdata_s = pins_sync[2];
    assign clr_n_s = pins_sync[3];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sel_n_d;
    logic sclk_d;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_n_d <= 1'b1;
            sclk_d  <= 1'b0;
        end else begin
            sel_n_d <= sel_n_s;
            sclk_d  <= sclk_s;
        end
    end

    logic sclk_rise;
    logic sel_rise;
    logic sel_fall;

    assign sclk_rise = rise(sclk_d, sclk_s);
    assign sel_rise  = rise(sel_n_d, sel_n_s);
    assign sel_fall  = rise(sel_n_s, sel_n_d);

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    dac_load_pkg::frame_state_e state;
    dac_load_pkg::frame_state_e next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            dac_load_pkg::FRAME_IDLE: begin
                if (sel_fall) begin
                    next_state = dac_load_pkg::FRAME_SHIFT;
                end
            end
            dac_load_pkg::FRAME_SHIFT: begin
                if (sel_rise) begin
                    next_state = dac_load_pkg::FRAME_IDLE;
                end
            end
            default: next_state = dac_load_pkg::FRAME_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= dac_load_pkg::FRAME_IDLE;
        end else begin
            state <= next_state;
        end
    end

    logic shifting;
    assign shifting = (state == dac_load_pkg::FRAME_SHIFT) && !sel_n_s;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frame_active <= 1'b0;
        end else begin
            frame_active <= (next_state == dac_load_pkg::FRAME_SHIFT);
        end
    end

    // ------------------------------------------------------------
    // Shift register and edge count
    // ------------------------------------------------------------
    logic [15:0] shift_reg;
    logic [4:0]  edge_count;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg <= 16'h0000;
        end else if (shifting && sclk_rise) begin
            shift_reg <= {shift_reg[14:0], sdata_s};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            edge_count <= 5'h00;
        end else if (sel_fall) begin
            edge_count <= 5'h00;
        end else if (shifting && sclk_rise && edge_count != 5'h10) begin
            edge_count <= edge_count + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // DAC latch, clear has priority over a load
    // ------------------------------------------------------------
    logic load_now;
    assign load_now = (state == dac_load_pkg::FRAME_SHIFT) && sel_rise;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dac_code <= CLEAR_CODE;
        end else if (!clr_n_s) begin
            dac_code <= CLEAR_CODE;
        end else if (load_now) begin
            dac_code <= shift_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dac_update  <= 1'b0;
            frame_short <= 1'b0;
        end else begin
            dac_update  <= (load_now && clr_n_s) || (!clr_n_s && dac_code != CLEAR_CODE);
            if (load_now) begin
                frame_short <= (edge_count < 5'h10);
            end
        end
    end

    // ------------------------------------------------------------
    // Power-up delay indicator
    // ------------------------------------------------------------
    logic [31:0] pu_count;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pu_count     <= 32'h0000_0000;
            powerup_done <= 1'b0;
        end else if (pu_count != PU_LAST) begin
            pu_count <= pu_count + 32'h0000_0001;
        end else begin
            powerup_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    clear_forces_code_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !clr_n_s |=> dac_code == CLEAR_CODE)
        else $error("clear did not force the clear code");

    load_copies_shift_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (load_now && clr_n_s) |=> dac_code == $past(shift_reg) && dac_update)
        else $error("select rise did not load the latch");

    latch_holds_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!load_now && clr_n_s) |=> $stable(dac_code))
        else $error("latch changed without load or clear");

    shift_on_edge_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (shifting && sclk_rise) |=> shift_reg[0] == $past(sdata_s) && shift_reg[15:1] == $past(shift_reg[14:0]))
        else $error("shift register did not take the data bit");

    idle_ignores_clk_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!shifting) |=> $stable(shift_reg))
        else $error("shift register moved outside a frame");

    short_frame_flag_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        load_now |=> frame_short == ($past(edge_count) < 5'h10))
        else $error("short frame flag wrong");

    powerup_timing_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (pu_count != PU_LAST) |-> !powerup_done)
        else $error("power-up indicator early");

    frame_tracks_sel_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        sel_fall |=> frame_active ##0 state == dac_load_pkg::FRAME_SHIFT)
        else $error("frame did not open on select fall");

endmodule
